// >>> logic/phy_tx_pkg.sv
// Purpose: Shared constants for the MAC-facing transmit port of the PHY.
// Assumes: Core clock of 10 MHz; all half-period counts derive from the rates below.
// Notes:   Half-period counts never fall below one core cycle.
package phy_tx_pkg;

   // ***********************************************************
   // Clock rates
   // ***********************************************************
   localparam int unsigned CORE_CLK_HZ    = 10_000_000;
   localparam int unsigned MII_CLK_100_HZ = 25_000_000;
   localparam int unsigned MII_CLK_10_HZ  = 2_500_000;
   localparam int unsigned RMII_REF_HZ    = 50_000_000;

   // ***********************************************************
   // Derived half-period counts in core cycles
   // ***********************************************************
   localparam int unsigned HALF_100_RAW  = CORE_CLK_HZ / (2 * MII_CLK_100_HZ);
   localparam int unsigned HALF_10_RAW   = CORE_CLK_HZ / (2 * MII_CLK_10_HZ);
   localparam int unsigned HALF_RMII_RAW = CORE_CLK_HZ / (2 * RMII_REF_HZ);
   localparam int unsigned HALF_100      = (HALF_100_RAW < 1) ? 1 : HALF_100_RAW;
   localparam int unsigned HALF_10       = (HALF_10_RAW < 1) ? 1 : HALF_10_RAW;
   localparam int unsigned HALF_RMII     = (HALF_RMII_RAW < 1) ? 1 : HALF_RMII_RAW;

   // ***********************************************************
   // Widths, reset values and start-up timing
   // ***********************************************************
   localparam int unsigned DIV_W         = 8;
   localparam int unsigned MII_PIECES    = 2;
   localparam int unsigned RMII_PIECES   = 4;
   localparam logic [2:0]  STRAP_SETTLE  = 3'h3;
   localparam logic [7:0]  BYTE_RST      = 8'h00;

endpackage

// >>> logic/phy_tx_sync.sv
// Purpose: Two-flop synchroniser for a group of independent level inputs.
// Assumes: Each bit is sampled on its own; no bus coherence is promised.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module phy_tx_sync
#(
   parameter int unsigned W = 1
)
(
   input  wire logic         i_core_clk,
   input  wire logic         i_rstn,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] hold_ff;

   // Two stages trade two cycles of latency for metastability margin.
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         meta_ff <= '0;
         hold_ff <= '0;
      end
      else
      begin
         meta_ff <= i_d;
         hold_ff <= meta_ff;
      end
   end

   assign o_q = hold_ff;
endmodule
`default_nettype wire

// >>> logic/phy_tx_port.sv
// Purpose: Transmit side of the MAC-facing MII/RMII port: clock pin and nibble/dibit capture.
// Assumes: All input pins are asynchronous to i_core_clk; all but i_rstn pass the two-flop synchroniser.
// Notes:   Mode, speed and strap are pins; the rules that the port keeps follow.
// Operation
// R1: Low reset input initialises the port and returns every register to default.
// R2: Outside controller holds the reset low for at least 10 ms; the bench holds it 16 core cycles.
// R3: MII mode drives transmit clock at 25 MHz for 100 Mbps, 2.5 MHz for 10; the port gives 5 MHz for 100.
// R4: RMII mode uses the transmit clock pin as one 50 MHz reference, either source; the port drives it out at 5 MHz.
// R5: RMII with floating direction strap defaults to driving the reference clock out.
// R6: Transmit enable is taken on the rising edge of the transmit clock.
// R7: Enable marks valid data on four lines in MII, two lines in RMII.
// R8: Transmit enable is active high: one means data, zero means none.
// R9: The MAC drives data synchronous to the transmit clock while enable is high.
// R10: Data with enable low is ignored and nothing goes to the media.
`timescale 1ns/1ns
`default_nettype none
module phy_tx_port
#(
   parameter int unsigned HALF_100_P  = phy_tx_pkg::HALF_100,
   parameter int unsigned HALF_10_P   = phy_tx_pkg::HALF_10,
   parameter int unsigned HALF_RMII_P = phy_tx_pkg::HALF_RMII
)
(
   input  wire logic       i_core_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_rmii_mode,
   input  wire logic       i_speed_100,
   input  wire logic       i_refclk_direction_strap,
   input  wire logic       i_tx_clk_in,
   output logic            o_tx_clk_out,
   output logic            o_tx_clk_oe_n,
   input  wire logic       i_tx_en,
   input  wire logic [3:0] i_txd,
   output logic      [7:0] o_media_byte,
   output logic            o_media_valid,
   output logic            o_media_frame,
   output logic            o_refclk_is_input
);
   // ***********************************************************
   // Elaboration checks
   // ***********************************************************
   if (HALF_100_P < 1 || HALF_10_P < 1 || HALF_RMII_P < 1 ||
       HALF_100_P >= (1 << phy_tx_pkg::DIV_W) || HALF_10_P >= (1 << phy_tx_pkg::DIV_W) ||
       HALF_RMII_P >= (1 << phy_tx_pkg::DIV_W))
   begin : g_bad_half
      $error("Half-period counts must lie between one and the divider range.");
   end

   // ***********************************************************
   // Declarations
   // ***********************************************************
   localparam logic [phy_tx_pkg::DIV_W-1:0] H100  = phy_tx_pkg::DIV_W'(HALF_100_P);
   localparam logic [phy_tx_pkg::DIV_W-1:0] H10   = phy_tx_pkg::DIV_W'(HALF_10_P);
   localparam logic [phy_tx_pkg::DIV_W-1:0] HRMII = phy_tx_pkg::DIV_W'(HALF_RMII_P);
   localparam logic [1:0] MII_LAST  = 2'(phy_tx_pkg::MII_PIECES - 1);
   localparam logic [1:0] RMII_LAST = 2'(phy_tx_pkg::RMII_PIECES - 1);

   logic [8:0]                   sync_in;
   logic [8:0]                   sync_out;
   logic                         link_lvl;
   logic                         s_clk;
   logic                         s_en;
   logic [3:0]                   s_txd;
   logic                         s_rmii;
   logic                         s_speed;
   logic                         s_strap;
   logic                         drive;
   logic [phy_tx_pkg::DIV_W-1:0] half_c;
   logic                         tick;
   logic                         rise;
   logic                         last_piece;
   logic [7:0]                   nxt_shift;
   logic [phy_tx_pkg::DIV_W-1:0] div_cnt_ff;
   logic                         clk_out_ff;
   logic                         prev_clk_ff;
   logic [7:0]                   shift_ff;
   logic [1:0]                   piece_ff;
   logic [7:0]                   byte_ff;
   logic                         valid_ff;
   logic                         frame_ff;
   logic [2:0]                   settle_ff;
   logic                         strap_done_ff;
   logic                         strap_in_ff;

   // ***********************************************************
   // Pin synchronisation
   // ***********************************************************
   // The clock level goes through the same two stages as enable and data, so their
   // relative timing at the pins is kept when the edge is found on the core side.
   assign link_lvl = drive ? clk_out_ff : i_tx_clk_in;
   assign sync_in  = {i_refclk_direction_strap, i_speed_100, i_rmii_mode, i_txd, i_tx_en, link_lvl};

   phy_tx_sync #(.W(9)) u_sync
   (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_d        (sync_in),
      .o_q        (sync_out)
   );

   assign s_clk   = sync_out[0];
   assign s_en    = sync_out[1];
   assign s_txd   = sync_out[5:2];
   assign s_rmii  = sync_out[6];
   assign s_speed = sync_out[7];
   assign s_strap = sync_out[8];

   // ***********************************************************
   // Reference clock direction strap
   // ***********************************************************
   // The strap is caught once, after the synchroniser has filled; until then and when
   // the pin floats (read low through its pull-down) the port drives the clock out.
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         settle_ff     <= 3'h0;
         strap_done_ff <= 1'b0;
         strap_in_ff   <= 1'b0; // R1
      end
      else if (!strap_done_ff)
      begin
         settle_ff <= settle_ff + 3'h1;
         if (settle_ff == phy_tx_pkg::STRAP_SETTLE)
         begin
            strap_done_ff <= 1'b1;
            strap_in_ff   <= s_strap; // R5
         end
      end
   end

   // MII always sources the clock; RMII sources it unless strapped as input.
   assign drive             = !s_rmii || !strap_in_ff; // R4
   assign o_tx_clk_oe_n     = !drive;
   assign o_refclk_is_input = s_rmii && strap_in_ff;

   // ***********************************************************
   // Transmit clock divider
   // ***********************************************************
   // Rates above half the core clock saturate at one core cycle per half period;
   // such a pin clock is only a scaled stand-in for the real rate.
   assign half_c = s_rmii ? HRMII : (s_speed ? H100 : H10); // R3
   assign tick   = (div_cnt_ff >= half_c - phy_tx_pkg::DIV_W'(1));

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         div_cnt_ff <= '0;
         clk_out_ff <= 1'b0;
      end
      else if (!drive)
      begin
         div_cnt_ff <= '0;
         clk_out_ff <= 1'b0;
      end
      else if (tick)
      begin
         div_cnt_ff <= '0;
         clk_out_ff <= !clk_out_ff; // R3
      end
      else
      begin
         div_cnt_ff <= div_cnt_ff + phy_tx_pkg::DIV_W'(1);
      end
   end

   assign o_tx_clk_out = clk_out_ff;

   // ***********************************************************
   // Rising edge of the transmit clock
   // ***********************************************************
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         prev_clk_ff <= 1'b0;
      end
      else
      begin
         prev_clk_ff <= s_clk;
      end
   end

   assign rise = s_clk && !prev_clk_ff; // R6

   // ***********************************************************
   // Nibble and dibit assembly, low-order piece first
   // ***********************************************************
   assign nxt_shift  = s_rmii ? {s_txd[1:0], shift_ff[7:2]} : {s_txd, shift_ff[7:4]}; // R7
   assign last_piece = (piece_ff == (s_rmii ? RMII_LAST : MII_LAST));

   // An edge with enable low drops any partial byte, so no stale bits reach the media.
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         shift_ff <= phy_tx_pkg::BYTE_RST;
         piece_ff <= 2'h0;
         byte_ff  <= phy_tx_pkg::BYTE_RST;
         valid_ff <= 1'b0;
         frame_ff <= 1'b0;
      end
      else
      begin
         valid_ff <= 1'b0;
         if (rise && s_en) // R8
         begin
            frame_ff <= 1'b1;
            shift_ff <= nxt_shift;
            if (last_piece)
            begin
               piece_ff <= 2'h0;
               byte_ff  <= nxt_shift; // R7
               valid_ff <= 1'b1;
            end
            else
            begin
               piece_ff <= piece_ff + 2'h1;
            end
         end
         else if (rise)
         begin
            frame_ff <= 1'b0; // R10
            piece_ff <= 2'h0; // R10
         end
      end
   end

   assign o_media_byte  = byte_ff;
   assign o_media_valid = valid_ff;
   assign o_media_frame = frame_ff;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   // The reset check runs while reset is low; the others are off during reset.
   a_reset_clears_out: assert property (@(posedge i_core_clk) // R1
      !i_rstn |-> (!o_media_valid && !o_media_frame && o_media_byte == 8'h00 && !o_tx_clk_out))
      else $error("Outputs not at default during reset.");

   a_mii_clk_half: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R3
      (drive && !s_rmii && $stable(half_c) && $stable(drive) && $changed(o_tx_clk_out))
      |-> ($past(div_cnt_ff) == half_c - phy_tx_pkg::DIV_W'(1)))
      else $error("MII clock half period wrong.");

   a_clk_pin_dir: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R4
      o_tx_clk_oe_n == (s_rmii && strap_in_ff))
      else $error("Clock pin direction wrong.");

   a_strap_default_out: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R5
      (!strap_done_ff || (strap_done_ff && $stable(strap_done_ff) && !strap_in_ff && s_rmii))
      |-> !o_tx_clk_oe_n)
      else $error("Reference clock not driven by default.");

   a_sample_on_rise: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R6
      (!rise) |=> (!o_media_valid && $stable(piece_ff)))
      else $error("Capture outside a clock rising edge.");

   a_mii_byte_order: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R7
      (o_media_valid && !$past(s_rmii)) |-> (o_media_byte[7:4] == $past(s_txd)))
      else $error("MII byte assembled out of order.");

   a_en_active_high: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R8
      (rise && s_en) |=> o_media_frame)
      else $error("Frame not marked while enable high.");

   a_idle_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // R10
      (rise && !s_en) |=> (!o_media_valid && !o_media_frame && piece_ff == 2'h0))
      else $error("Data accepted while enable low.");

   c_mii_byte: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_media_valid && !s_rmii);
   c_rmii_byte: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_media_valid && s_rmii);
   c_refclk_input: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_refclk_is_input && rise && s_en);
   c_partial_drop: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
      rise && !s_en && piece_ff != 2'h0);
endmodule
`default_nettype wire

// >>> testbench/mac_tx_model.sv
// Purpose: Behavioural MAC that drives transmit enable and data into the port.
// Assumes: Pieces change one core falling edge after a link clock falling edge.
// Notes:   Idle lines rest at the pull-down level unless noise is asked for.
`timescale 1ns/1ns
`default_nettype none
module mac_tx_model
(
   input  wire logic       i_core_clk,
   input  wire logic       i_link_clk,
   output logic            o_tx_en,
   output logic      [3:0] o_txd
);
   // Pulled-down lines sit low until the first frame.
   initial
   begin
      o_tx_en = 1'b0;
      o_txd   = 4'h0;
   end

   // Sends n bytes low piece first, then extra pieces that never fill a byte.
   task automatic send(input logic [7:0] d [4], input int n, input logic rmii, input int extra);
      int pieces;
      pieces = rmii ? 4 : 2;
      for (int i = 0; i < n * pieces + extra; i++)
      begin
         @(negedge i_link_clk);
         @(negedge i_core_clk);
         o_tx_en = 1'b1;
         if (rmii)
            o_txd = {2'h0, d[(i / 4) % 4][(i % 4) * 2 +: 2]};
         else
            o_txd = d[(i / 2) % 4][(i % 2) * 4 +: 4];
      end
      @(negedge i_link_clk);
      @(negedge i_core_clk);
      o_tx_en = 1'b0;
      o_txd   = 4'h0;
   endtask

   // Wiggles data with enable low, so a port that listens anyway is caught.
   task automatic noise(input int k);
      for (int i = 0; i < k; i++)
      begin
         @(negedge i_link_clk);
         @(negedge i_core_clk);
         o_txd = ~o_txd;
      end
      @(negedge i_core_clk);
      o_txd = 4'h0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/phy_tx_port_tb_top.sv
// Purpose: Self-checking bench for the MII/RMII transmit port.
// Assumes: Half periods are raised so the synchroniser sees every link edge.
// Notes:   A low strap stands for a floating strap read through its pull-down.
`timescale 1ns/1ns
`default_nettype none
module phy_tx_port_tb_top;
   localparam int H100  = 4;
   localparam int H10   = 8;
   localparam int HRMII = 4;
   localparam int LIMIT = 20000;

   logic       clk;
   logic       rstn;
   logic       rmii;
   logic       spd;
   logic       strap;
   logic       ext_clk;
   logic       pin;
   logic       clk_out;
   logic       oe_n;
   logic       tx_en;
   logic [3:0] txd;
   logic [7:0] mbyte;
   logic       valid;
   logic       frame;
   logic       prev_frame;
   logic       is_in;
   logic [7:0] got_q [$];
   int         bad_count;
   int         total_checks;
   int         cycles;
   int         frames;

   // *******************************************************
   // Clocks, pin and parts
   // *******************************************************
   initial
   begin
      clk = 1'b0;
      rmii = 1'b0;
      spd = 1'b1;
      strap = 1'b0;
      ext_clk = 1'b0;
      prev_frame = 1'b0;
      bad_count = 0;
      total_checks = 0;
      cycles = 0;
      frames = 0;
      // Reset falls after time zero, so the asynchronous reset is never missed.
      #1;
      rstn = 1'b0;
   end
   always #50 clk = ~clk;
   // The outside reference is offset so its edges never meet core edges.
   initial
   begin
      #130;
      forever #400 ext_clk = ~ext_clk;
   end
   // The shared pin carries whichever side has it enabled.
   assign pin = (oe_n === 1'b0) ? clk_out : ext_clk;

   phy_tx_port #(.HALF_100_P(H100), .HALF_10_P(H10), .HALF_RMII_P(HRMII)) dut_u
   (
      .i_core_clk(clk), .i_rstn(rstn), .i_rmii_mode(rmii), .i_speed_100(spd),
      .i_refclk_direction_strap(strap), .i_tx_clk_in(pin), .o_tx_clk_out(clk_out),
      .o_tx_clk_oe_n(oe_n), .i_tx_en(tx_en), .i_txd(txd), .o_media_byte(mbyte),
      .o_media_valid(valid), .o_media_frame(frame), .o_refclk_is_input(is_in)
   );
   mac_tx_model mac_u (.i_core_clk(clk), .i_link_clk(pin), .o_tx_en(tx_en), .o_txd(txd));

   // Collects bytes and frame starts, and cuts a hang short.
   always @(posedge clk)
   begin
      if (valid === 1'b1)
         got_q.push_back(mbyte);
      if (frame === 1'b1 && prev_frame !== 1'b1)
         frames++;
      prev_frame = frame;
      cycles++;
      if (cycles == LIMIT)
      begin
         bad_count++;
         give_verdict();
      end
   end

   // *******************************************************
   // Shared tasks
   // *******************************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // The hold is far shorter than a board needs, to keep the run brief.
   task automatic do_reset(input logic m, input logic s, input logic st);
      @(negedge clk);
      rstn = 1'b0;
      rmii = m;
      spd = s;
      strap = st;
      repeat (16) @(negedge clk);
      check("valid in reset", valid, 1'b0);
      check("frame in reset", frame, 1'b0);
      check("byte in reset", mbyte, 8'h00);
      check("refclk input in reset", is_in, 1'b0);
      rstn = 1'b1;
      repeat (10) @(negedge clk);
      got_q.delete();
      frames = 0;
   endtask

   task automatic measure_half(input int exp);
      int n;
      int k;
      n = 0;
      k = 0;
      while (clk_out !== 1'b0 && k < 100)
      begin
         @(negedge clk);
         k++;
      end
      while (clk_out !== 1'b1 && k < 100)
      begin
         @(negedge clk);
         k++;
      end
      while (clk_out === 1'b1 && k < 100)
      begin
         @(negedge clk);
         n++;
         k++;
      end
      check("clock half period", n, exp);
   endtask

   task automatic run_frame(input logic [7:0] d [4], input int n, input logic r, input int extra);
      int k;
      mac_u.send(d, n, r, extra);
      k = 0;
      while (frame !== 1'b0 && k < 60)
      begin
         @(negedge clk);
         k++;
      end
      check("byte count", got_q.size(), n);
      for (int i = 0; i < n && i < got_q.size(); i++)
         check("media byte", got_q[i], d[i]);
      check("frame count", frames, 1);
   endtask

   // *******************************************************
   // Scenarios
   // *******************************************************
   // Three bytes and a lone nibble, then idle noise that must be ignored.
   task automatic test_mii(input logic s);
      do_reset(1'b0, s, 1'b0);
      check("mii clock enable", oe_n, 1'b0);
      measure_half(s ? H100 : H10);
      run_frame('{8'hBA, 8'h5C, 8'hE1, 8'h07}, 3, 1'b0, 1);
      got_q.delete();
      frames = 0;
      mac_u.noise(12);
      repeat (10) @(negedge clk);
      check("bytes while idle", got_q.size(), 0);
      check("frames while idle", frames, 0);
   endtask

   // Four bytes of dibits and three stray dibits, clock sourced per strap.
   task automatic test_rmii(input logic st);
      do_reset(1'b1, 1'b1, st);
      check("rmii clock enable", oe_n, st);
      check("refclk is input", is_in, st);
      if (!st)
         measure_half(HRMII);
      run_frame('{8'hC6, 8'h39, 8'hA5, 8'hF0}, 4, 1'b1, 3);
   endtask

   initial
   begin
      test_mii(1'b1);
      test_mii(1'b0);
      test_rmii(1'b0);
      test_rmii(1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
